/* hw/fnsrc_pkg.sv */
// Constants, field layouts and carrier types for the synthesizer control bank.
// Assumes a single 25 MHz reference clock domain.
package fnsrc_pkg;

  localparam int WORD_W = 24;
  localparam int SEL_W = 3;

  // Register select codes
  localparam logic [2:0] SEL_CHANNEL = 3'h0;
  localparam logic [2:0] SEL_MODREF = 3'h1;
  localparam logic [2:0] SEL_PHASE = 3'h2;
  localparam logic [2:0] SEL_FUNC = 3'h3;
  localparam logic [2:0] SEL_PUMP = 3'h4;
  localparam logic [2:0] SEL_PDOWN = 3'h5;
  localparam logic [2:0] SEL_MUX = 3'h6;
  localparam logic [2:0] SEL_TEST = 3'h7;

  // Channel word fields
  localparam int INT_LSB = 15;
  localparam int INT_W = 8;
  localparam int FRACTION_NUMERATOR_LSB = 3;
  localparam int FRACTION_NUMERATOR_W = 12;

  // Modulus/reference fields
  localparam int BOOST_BIT = 23;
  localparam int HALVE_BIT = 22;
  localparam int PRESC_BIT = 20;
  localparam int DBL_BIT = 19;
  localparam int RDIV_LSB = 15;
  localparam int RDIV_W = 4;
  localparam int MOD_LSB = 3;
  localparam int MOD_W = 12;

  // Phase word field
  localparam int PHASE_LSB = 3;
  localparam int PHASE_W = 12;

  // Function fields
  localparam int FN_GNDREL_BIT = 5;
  localparam int FN_POL_BIT = 3;

  // Pump timer fields
  localparam int TMR_LSB = 5;
  localparam int TMR_W = 9;
  localparam int TSEL_LSB = 3;
  localparam int TSEL_W = 2;
  localparam logic [1:0] TSEL_CURRENT = 2'h2;
  localparam logic [1:0] TSEL_SW_AB = 2'h1;
  localparam logic [1:0] TSEL_SW_C = 2'h0;

  // Power-down fields
  localparam int PD_AMP_LSB = 6;
  // Amplifier starts powered down until the host clears it
  localparam logic [1:0] PD_AMP_RST = 2'h3;
  localparam int PD_PUMP_BIT = 5;
  localparam int PD_TRI_BIT = 4;
  localparam int PD_CRST_BIT = 3;

  // Mux register fields
  localparam int MODE_LSB = 12;
  localparam int MODE_W = 4;
  localparam int MUXSEL_LSB = 3;
  localparam int MUXSEL_W = 4;
  localparam logic [3:0] MODE_DEFAULT = 4'h0;
  localparam logic [3:0] MODE_DITHER = 4'h3;
  localparam logic [3:0] MODE_LD_WIDE = 4'h9;

  // Timers tick once every four phase-detector cycles
  localparam int TICK_DIV = 4;
  localparam logic [1:0] TICK_LAST = 2'(TICK_DIV - 1);
  localparam int RAMP_STEPS = 6;
  localparam logic [6:0] PUMP_CELLS_MAX = 7'h40;
  localparam logic [6:0] PUMP_CELLS_MIN = 7'h01;

  typedef struct packed {
    logic boost;
    logic halve;
    logic prescaler;
    logic doubler;
    logic [RDIV_W-1:0] rdiv;
    logic [MOD_W-1:0] modulus;
  } fnsrc_modref_t;

  typedef struct packed {
    logic [INT_W-1:0] int_word;
    logic [FRACTION_NUMERATOR_W-1:0] fraction_numerator_num;
    logic [PHASE_W-1:0] phase_seed;
    fnsrc_modref_t modref;
  } fnsrc_active_t;

  typedef struct packed {
    logic [6:0] pump_cells;
    logic pump_boost;
    logic filter_switch_a;
    logic filter_switch_b;
    logic filter_switch_c;
    logic fast_lock;
  } fnsrc_lock_t;

endpackage : fnsrc_pkg

/* hw/fnsrc_pin_sync.sv */
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module fnsrc_pin_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic level_out,
  output logic rise_pulse
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Change accepted only when the two later stages agree
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      level_reg <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      level_reg <= s3_reg;
    end
  end

  assign level_out = level_reg;
  assign rise_pulse = (s2_reg == s3_reg) && s3_reg && !level_reg;
endmodule : fnsrc_pin_sync
`default_nettype wire

/* hw/fnsrc_ctrl.sv */
// Serial-programmed control bank of a fractional-N synthesizer.
// Assumes ref_clk is the phase-detector reference; serial pins are async.
//
// Behaviour
// - Next reference cycle after channel latch loads integer and fraction.
// - Same cycle starts fast lock: full pump current, switches closed.
// - Modulus-register settings wait in a shadow until a channel write.
// - Select code 000 loads the channel word.
// - Select code 001 loads the modulus and reference word.
// - Fraction feeds modulator; host keeps it below the modulus.
// - Boost bit raises pump current 25 percent at channel write.
// - Halver bit adds divide-by-two before the phase detector.
// - Doubler bit puts doubler ahead of the reference divider.
// - Phase word seeds the modulator, range zero to modulus.
// - Phase word waits for the next channel latch.
// - Shift 24 bits MSB first on clock rise; latch on strobe rise.
// - Timers tick at quarter rate; pump steps 64 to 1 over six ticks.
// - Timer select 10 current, 01 switches a/b, 00 switch c.
// - Mode 0000 defaults, 0011 dither, 1001 wide lock threshold.
`timescale 1ns/1ps
`default_nettype none
module fnsrc_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic latch_strobe,
  output fnsrc_pkg::fnsrc_active_t active,
  output fnsrc_pkg::fnsrc_lock_t lock_state,
  output logic divider_load,
  output logic dither_en,
  output logic lock_wide_thresh,
  output logic [fnsrc_pkg::MUXSEL_W-1:0] mux_select,
  output logic pump_ground_release,
  output logic pfd_polarity,
  output logic [1:0] power_amp_down,
  output logic power_pump_down,
  output logic pump_tristate,
  output logic counter_reset,
  output logic [fnsrc_pkg::WORD_W-1:0] test_word
);
  typedef enum logic [2:0] {
    FNSRC_IDLE = 3'b001,
    FNSRC_HOLD = 3'b010,
    FNSRC_RAMP = 3'b100
  } fnsrc_pump_t;

  logic sclk_level;
  logic sclk_rise;
  logic sdat_level;
  logic le_level;
  logic le_rise;
  logic [fnsrc_pkg::WORD_W-1:0] shift_reg;
  logic [fnsrc_pkg::SEL_W-1:0] sel;
  logic reg_select_bit_high;
  logic reg_select_bit_mid;
  logic reg_select_bit_low;
  fnsrc_pkg::fnsrc_modref_t modref_shadow_reg;
  logic [fnsrc_pkg::PHASE_W-1:0] phase_shadow_reg;
  logic [fnsrc_pkg::INT_W-1:0] int_shadow_reg;
  logic [fnsrc_pkg::FRACTION_NUMERATOR_W-1:0] fraction_numerator_shadow_reg;
  logic apply_reg;
  fnsrc_pkg::fnsrc_active_t active_reg;
  logic [fnsrc_pkg::TMR_W-1:0] cur_limit_reg;
  logic [fnsrc_pkg::TMR_W-1:0] swab_limit_reg;
  logic [fnsrc_pkg::TMR_W-1:0] swc_limit_reg;
  logic [1:0] tick_cnt_reg;
  logic tick;
  logic [fnsrc_pkg::TMR_W-1:0] cur_cnt_reg;
  logic [fnsrc_pkg::TMR_W-1:0] swab_cnt_reg;
  logic [fnsrc_pkg::TMR_W-1:0] swc_cnt_reg;
  logic swab_closed_reg;
  logic swc_closed_reg;
  fnsrc_pump_t pump_state_reg;
  logic [2:0] ramp_cnt_reg;
  logic [6:0] cells_reg;
  logic boost_reg;
  logic [fnsrc_pkg::MODE_W-1:0] mode_reg;
  logic [fnsrc_pkg::MUXSEL_W-1:0] muxsel_reg;
  logic gndrel_reg;
  logic pol_reg;
  logic [1:0] amp_pd_reg;
  logic pump_pd_reg;
  logic tri_reg;
  logic crst_reg;
  logic [fnsrc_pkg::WORD_W-1:0] test_reg;

  fnsrc_pin_sync u_sclk (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(serial_clk),
    .level_out(sclk_level),
    .rise_pulse(sclk_rise)
  );

  fnsrc_pin_sync u_sdat (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(serial_data),
    .level_out(sdat_level),
    .rise_pulse()
  );

  fnsrc_pin_sync u_le (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(latch_strobe),
    .level_out(le_level),
    .rise_pulse(le_rise)
  );

  // MSB first: new bit enters at the bottom
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shift_reg <= '0;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[fnsrc_pkg::WORD_W-2:0], sdat_level};
    end
  end

  assign reg_select_bit_high = shift_reg[2];
  assign reg_select_bit_mid = shift_reg[1];
  assign reg_select_bit_low = shift_reg[0];
  assign sel = {reg_select_bit_high, reg_select_bit_mid, reg_select_bit_low};

  // Shadow copies, applied only by a channel latch
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      modref_shadow_reg <= '0;
      phase_shadow_reg <= '0;
      int_shadow_reg <= '0;
      fraction_numerator_shadow_reg <= '0;
      apply_reg <= 1'b0;
    end else begin
      apply_reg <= 1'b0;
      if (le_rise) begin
        case (sel)
          fnsrc_pkg::SEL_CHANNEL: begin
            int_shadow_reg <= shift_reg[fnsrc_pkg::INT_LSB +:
                                        fnsrc_pkg::INT_W];
            fraction_numerator_shadow_reg <= shift_reg[fnsrc_pkg::FRACTION_NUMERATOR_LSB +:
                                         fnsrc_pkg::FRACTION_NUMERATOR_W];
            apply_reg <= 1'b1;
          end
          fnsrc_pkg::SEL_MODREF: begin
            modref_shadow_reg.boost <= shift_reg[fnsrc_pkg::BOOST_BIT];
            modref_shadow_reg.halve <= shift_reg[fnsrc_pkg::HALVE_BIT];
            modref_shadow_reg.prescaler <= shift_reg[fnsrc_pkg::PRESC_BIT];
            modref_shadow_reg.doubler <= shift_reg[fnsrc_pkg::DBL_BIT];
            modref_shadow_reg.rdiv <= shift_reg[fnsrc_pkg::RDIV_LSB +:
                                                fnsrc_pkg::RDIV_W];
            modref_shadow_reg.modulus <= shift_reg[fnsrc_pkg::MOD_LSB +:
                                                   fnsrc_pkg::MOD_W];
          end
          fnsrc_pkg::SEL_PHASE: begin
            phase_shadow_reg <= shift_reg[fnsrc_pkg::PHASE_LSB +:
                                          fnsrc_pkg::PHASE_W];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // One reference cycle after the latch the divider takes the new values
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      active_reg <= '0;
    end else if (apply_reg) begin
      active_reg.int_word <= int_shadow_reg;
      active_reg.fraction_numerator_num <= fraction_numerator_shadow_reg;
      active_reg.phase_seed <= phase_shadow_reg;
      active_reg.modref <= modref_shadow_reg;
    end
  end

  // Directly-effective setup registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur_limit_reg <= '0;
      swab_limit_reg <= '0;
      swc_limit_reg <= '0;
      mode_reg <= fnsrc_pkg::MODE_DEFAULT;
      muxsel_reg <= '0;
      gndrel_reg <= 1'b0;
      pol_reg <= 1'b0;
      amp_pd_reg <= fnsrc_pkg::PD_AMP_RST;
      pump_pd_reg <= 1'b1;
      tri_reg <= 1'b0;
      crst_reg <= 1'b0;
      test_reg <= '0;
    end else if (le_rise) begin
      case (sel)
        fnsrc_pkg::SEL_FUNC: begin
          gndrel_reg <= shift_reg[fnsrc_pkg::FN_GNDREL_BIT];
          pol_reg <= shift_reg[fnsrc_pkg::FN_POL_BIT];
        end
        fnsrc_pkg::SEL_PUMP: begin
          case (shift_reg[fnsrc_pkg::TSEL_LSB +: fnsrc_pkg::TSEL_W])
            fnsrc_pkg::TSEL_CURRENT: cur_limit_reg <=
              shift_reg[fnsrc_pkg::TMR_LSB +: fnsrc_pkg::TMR_W];
            fnsrc_pkg::TSEL_SW_AB: swab_limit_reg <=
              shift_reg[fnsrc_pkg::TMR_LSB +: fnsrc_pkg::TMR_W];
            fnsrc_pkg::TSEL_SW_C: swc_limit_reg <=
              shift_reg[fnsrc_pkg::TMR_LSB +: fnsrc_pkg::TMR_W];
            default: begin
            end
          endcase
        end
        fnsrc_pkg::SEL_PDOWN: begin
          amp_pd_reg <= shift_reg[fnsrc_pkg::PD_AMP_LSB +: 2];
          pump_pd_reg <= shift_reg[fnsrc_pkg::PD_PUMP_BIT];
          tri_reg <= shift_reg[fnsrc_pkg::PD_TRI_BIT];
          crst_reg <= shift_reg[fnsrc_pkg::PD_CRST_BIT];
        end
        fnsrc_pkg::SEL_MUX: begin
          mode_reg <= shift_reg[fnsrc_pkg::MODE_LSB +: fnsrc_pkg::MODE_W];
          muxsel_reg <= shift_reg[fnsrc_pkg::MUXSEL_LSB +:
                                  fnsrc_pkg::MUXSEL_W];
        end
        fnsrc_pkg::SEL_TEST: begin
          test_reg <= shift_reg;
        end
        default: begin
        end
      endcase
    end
  end

  // Quarter-rate tick; restarted on apply so timing is aligned to the write
  always_ff @(posedge ref_clk) begin
    if (!rst_n || apply_reg) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 2'h1;
    end
  end

  assign tick = (tick_cnt_reg == fnsrc_pkg::TICK_LAST);

  // Switch timers: closed from the apply until their count is reached
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      swab_cnt_reg <= '0;
      swc_cnt_reg <= '0;
      swab_closed_reg <= 1'b0;
      swc_closed_reg <= 1'b0;
    end else if (apply_reg) begin
      swab_cnt_reg <= '0;
      swc_cnt_reg <= '0;
      swab_closed_reg <= 1'b1;
      swc_closed_reg <= 1'b1;
    end else if (tick) begin
      if (swab_closed_reg) begin
        swab_cnt_reg <= swab_cnt_reg + 9'h001;
        if (swab_cnt_reg + 9'h001 >= swab_limit_reg) begin
          swab_closed_reg <= 1'b0;
        end
      end
      if (swc_closed_reg) begin
        swc_cnt_reg <= swc_cnt_reg + 9'h001;
        if (swc_cnt_reg + 9'h001 >= swc_limit_reg) begin
          swc_closed_reg <= 1'b0;
        end
      end
    end
  end

  // Pump current: hold at 64 cells, then halve on each tick down to 1
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pump_state_reg <= FNSRC_IDLE;
      cur_cnt_reg <= '0;
      ramp_cnt_reg <= '0;
      cells_reg <= fnsrc_pkg::PUMP_CELLS_MIN;
      boost_reg <= 1'b0;
    end else if (apply_reg) begin
      pump_state_reg <= FNSRC_HOLD;
      cur_cnt_reg <= '0;
      ramp_cnt_reg <= '0;
      cells_reg <= fnsrc_pkg::PUMP_CELLS_MAX;
      boost_reg <= modref_shadow_reg.boost;
    end else if (tick) begin
      case (pump_state_reg)
        FNSRC_HOLD: begin
          cur_cnt_reg <= cur_cnt_reg + 9'h001;
          if (cur_cnt_reg + 9'h001 >= cur_limit_reg) begin
            pump_state_reg <= FNSRC_RAMP;
          end
        end
        FNSRC_RAMP: begin
          cells_reg <= cells_reg >> 1;
          ramp_cnt_reg <= ramp_cnt_reg + 3'h1;
          if (ramp_cnt_reg == 3'(fnsrc_pkg::RAMP_STEPS - 1)) begin
            pump_state_reg <= FNSRC_IDLE;
          end
        end
        FNSRC_IDLE: begin
        end
        default: pump_state_reg <= FNSRC_IDLE;
      endcase
    end
  end

  assign active = active_reg;
  assign divider_load = apply_reg;
  assign lock_state = '{pump_cells: cells_reg,
                        pump_boost: boost_reg,
                        filter_switch_a: swab_closed_reg,
                        filter_switch_b: swab_closed_reg,
                        filter_switch_c: swc_closed_reg,
                        fast_lock: (pump_state_reg != FNSRC_IDLE)};
  assign dither_en = (mode_reg == fnsrc_pkg::MODE_DITHER);
  assign lock_wide_thresh = (mode_reg == fnsrc_pkg::MODE_LD_WIDE);
  assign mux_select = muxsel_reg;
  assign pump_ground_release = gndrel_reg;
  assign pfd_polarity = pol_reg;
  assign power_amp_down = amp_pd_reg;
  assign power_pump_down = pump_pd_reg;
  assign pump_tristate = tri_reg;
  assign counter_reset = crst_reg;
  assign test_word = test_reg;
endmodule : fnsrc_ctrl
`default_nettype wire

/* sim/fnsrc_host_model.sv */
// Host controller model driving the three-wire programming pins.
// Assumes ref_clk is the device reference; pins change on its rise.
`timescale 1ns/1ps
`default_nettype none
module fnsrc_host_model (
  input wire logic ref_clk,
  output logic serial_clk,
  output logic serial_data,
  output logic latch_strobe
);
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    latch_strobe = 1'b0;
  end

  // Half period of four reference cycles gives the 320 ns link clock
  task automatic send(input logic [23:0] w);
    int i;
    @(posedge ref_clk);
    for (i = 23; i >= 0; i--) begin
      serial_data <= w[i];
      repeat (4) @(posedge ref_clk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      serial_clk <= 1'b0;
    end
    // Data line goes stale after the frame, never repeats the last bit
    serial_data <= ~w[0];
    repeat (4) @(posedge ref_clk);
    // Fixed frame length from a reference edge pins the latch cycle
    latch_strobe <= 1'b1;
    repeat (4) @(posedge ref_clk);
    latch_strobe <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : send
endmodule : fnsrc_host_model
`default_nettype wire

/* sim/fnsrc_ctrl_sva.sv */
// Checker for the synthesizer control bank, bound to fnsrc_ctrl.
// Assumes one ref_clk domain with synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module fnsrc_ctrl_sva (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire fnsrc_pkg::fnsrc_active_t active,
  input wire fnsrc_pkg::fnsrc_lock_t lock_state,
  input wire logic divider_load,
  input wire logic dither_en,
  input wire logic lock_wide_thresh
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_pulse; divider_load |=> !divider_load; endproperty
  a_pulse: assert property (p_pulse)
    else $error("divider load longer than one cycle");
  property p_cells; divider_load |=> lock_state.pump_cells == 7'h40;
  endproperty
  a_cells: assert property (p_cells)
    else $error("pump not at full current after load");
  property p_sw;
    divider_load |=> lock_state.fast_lock && lock_state.filter_switch_a &&
      lock_state.filter_switch_b && lock_state.filter_switch_c;
  endproperty
  a_sw: assert property (p_sw)
    else $error("fast lock or switches not set after load");
  property p_close;
    $rose(lock_state.filter_switch_a) |-> $past(divider_load);
  endproperty
  a_close: assert property (p_close)
    else $error("switch closed without a channel load");
  // Shadowed settings may only move on the cycle after a load
  property p_hold; !$past(divider_load) |-> $stable(active); endproperty
  a_hold: assert property (p_hold)
    else $error("applied settings moved without a load");
  property p_boost;
    divider_load |=> lock_state.pump_boost == active.modref.boost;
  endproperty
  a_boost: assert property (p_boost)
    else $error("pump boost does not follow applied boost");
  property p_mode; !(dither_en && lock_wide_thresh); endproperty
  a_mode: assert property (p_mode)
    else $error("two modes decoded at once");
  property p_half;
    $changed(lock_state.pump_cells) && !$past(divider_load) |->
      lock_state.pump_cells == ($past(lock_state.pump_cells) >> 1);
  endproperty
  a_half: assert property (p_half)
    else $error("pump cells did not halve");
  property p_space;
    $changed(lock_state.pump_cells) && !$past(divider_load) |=>
      ($stable(lock_state.pump_cells) || $past(divider_load))[*3];
  endproperty
  a_space: assert property (p_space)
    else $error("ramp step faster than quarter rate");
  property p_onehot; $onehot(lock_state.pump_cells); endproperty
  a_onehot: assert property (p_onehot)
    else $error("pump cells not a binary step");

  c_load: cover property (divider_load);
  c_ramp_end: cover property (lock_state.pump_cells == 7'h01 &&
    $past(lock_state.pump_cells) == 7'h02);
  c_sw_open: cover property ($fell(lock_state.filter_switch_c));
  c_dither: cover property (dither_en);
endmodule : fnsrc_ctrl_sva

bind fnsrc_ctrl fnsrc_ctrl_sva i_fnsrc_ctrl_sva (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .active(active),
  .lock_state(lock_state),
  .divider_load(divider_load),
  .dither_en(dither_en),
  .lock_wide_thresh(lock_wide_thresh)
);
`default_nettype wire

/* sim/test_fracn_synth_register_control.sv */
// Self-checking bench for fnsrc_ctrl driven by the host pin model.
// Assumes fnsrc_host_model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module test_fracn_synth_register_control;
  typedef struct packed {
    logic [23:0] w;
    logic [36:0] e;
  } fnsrc_row_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  wire logic serial_clk, serial_data, latch_strobe;
  fnsrc_pkg::fnsrc_active_t active;
  fnsrc_pkg::fnsrc_lock_t lock_state;
  logic divider_load, dither_en, lock_wide_thresh, pump_ground_release;
  logic pfd_polarity, power_pump_down, pump_tristate, counter_reset;
  logic [fnsrc_pkg::MUXSEL_W-1:0] mux_select;
  logic [1:0] power_amp_down;
  logic [23:0] test_word;
  logic [36:0] snap;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int ld_cyc = 0;
  int tc, tab, tcell, k;
  // Reserved bits hold their fixed layout values
  fnsrc_row_t rows [6] = '{
    '{24'h00007b, 37'h7c}, '{24'h00001d, 37'h63},
    '{24'h00302e, 37'h12e3}, '{24'h009056, 37'hd63},
    '{24'h000007, 37'hed63}, '{24'h000006, 37'he063}};

  assign snap = {test_word, dither_en, lock_wide_thresh, mux_select,
    pump_ground_release, pfd_polarity, power_amp_down, power_pump_down,
    pump_tristate, counter_reset};
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (divider_load === 1'b1) ld_cyc <= cyc;
  end

  fnsrc_host_model i_fnsrc_host_model (
    .ref_clk(ref_clk),
    .serial_clk(serial_clk),
    .serial_data(serial_data),
    .latch_strobe(latch_strobe)
  );
  fnsrc_ctrl i_fnsrc_ctrl (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .serial_clk(serial_clk),
    .serial_data(serial_data),
    .latch_strobe(latch_strobe),
    .active(active),
    .lock_state(lock_state),
    .divider_load(divider_load),
    .dither_en(dither_en),
    .lock_wide_thresh(lock_wide_thresh),
    .mux_select(mux_select),
    .pump_ground_release(pump_ground_release),
    .pfd_polarity(pfd_polarity),
    .power_amp_down(power_amp_down),
    .power_pump_down(power_pump_down),
    .pump_tristate(pump_tristate),
    .counter_reset(counter_reset),
    .test_word(test_word)
  );

  // Settle time covers the three-flop pin filter and decode
  task automatic wr(input logic [23:0] w);
    i_fnsrc_host_model.send(w);
    repeat (8) @(negedge ref_clk);
  endtask : wr

  task automatic chk_rst;
    `CHK(snap, 37'h1c)
    `CHK(active, 52'h0)
    `CHK(lock_state, 12'h020)
  endtask : chk_rst

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // About 3100 cycles of traffic expected
  initial begin
    #800000;
    n_fail++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk_rst();
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].w);
      `CHK(snap, rows[i].e)
    end
    $display("register rows done");
    wr(24'hc98321);
    wr(24'h00012a);
    `CHK(active, 52'h0)
    wr(24'h0040b4);
    wr(24'h0041cc);
    wr(24'h0040a4);
    wr(24'h140038);
    `CHK(active.int_word, 8'h28)
    `CHK(active.fraction_numerator_num, 12'h007)
    `CHK(active.phase_seed, 12'h025)
    `CHK(active.modref, {4'hd, 4'h3, 12'h064})
    `CHK(lock_state, 12'h81f)
    tc = 0;
    tab = 0;
    tcell = 0;
    for (k = 0; k < 80; k++) begin
      @(negedge ref_clk);
      if (tc == 0 && lock_state.filter_switch_c === 1'b0) tc = cyc - ld_cyc;
      if (tab == 0 && lock_state.filter_switch_a === 1'b0) tab = cyc - ld_cyc;
      if (tcell == 0 && lock_state.pump_cells === 7'h01) tcell = cyc - ld_cyc;
    end
    `CHK(tc inside {[16:26]}, 1'b1)
    `CHK(tab inside {[52:62]}, 1'b1)
    `CHK(tcell inside {[40:52]}, 1'b1)
    `CHK(lock_state.filter_switch_b, 1'b0)
    $display("fast lock test done");
    // Lowest legal divider and modulus, prescaler bit set
    wr(24'h108069);
    wr(24'h0d0060);
    `CHK(active, 52'h1a00c0252100d)
    `CHK(lock_state, 12'h80f)
    $display("boost clear test done");
    // Reset lands in the fast-lock hold phase, before any ramp step, to prove the pump state clears
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk_rst();
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule : test_fracn_synth_register_control
`default_nettype wire
